// ===== rtl/ufer_pkg.sv
package ufer_pkg;

  // ****************************************
  // register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [7:0] UFER_EP0_DATA_FIRST = 8'h20;
  localparam logic [7:0] UFER_EP0_DATA_LAST = 8'h27;
  localparam logic [7:0] UFER_EP12_DATA_FIRST = 8'h28;
  localparam logic [7:0] UFER_EP12_DATA_LAST = 8'h2F;
  localparam logic [7:0] UFER_ENDPOINT_CONTROL_TWO = 8'h37;
  localparam logic [7:0] UFER_FUNCTION_ADDRESS = 8'h38;
  localparam logic [7:0] UFER_EVENT_FLAGS_ZERO = 8'h39;
  localparam logic [7:0] UFER_EVENT_FLAGS_ONE = 8'h3A;
  localparam logic [7:0] UFER_ENDPOINT_CONTROL_ZERO = 8'h3B;
  localparam logic [7:0] UFER_ENDPOINT_CONTROL_ONE = 8'h3C;
  localparam logic [7:0] UFER_RECEIVE_STATUS = 8'h3D;

  // ****************************************
  // field positions
  // ****************************************
  localparam int UFER_ENABLE_BIT = 7;
  localparam int UFER_F0_TX_DONE = 7;
  localparam int UFER_F0_RX_DONE = 6;
  localparam int UFER_F0_BUS_RESET = 5;
  localparam int UFER_F0_SUSPEND = 4;
  localparam int UFER_F0_TX_IE = 3;
  localparam int UFER_F0_RX_IE = 2;
  localparam int UFER_F0_TX_CLR = 1;
  localparam int UFER_F0_RX_CLR = 0;
  localparam int UFER_F1_TX_DONE = 7;
  localparam int UFER_F1_EOP = 6;
  localparam int UFER_F1_RESUME = 5;
  localparam int UFER_F1_RESUME_CLR = 4;
  localparam int UFER_F1_TX_IE = 3;
  localparam int UFER_F1_EOP_IE = 2;
  localparam int UFER_F1_TX_CLR = 1;
  localparam int UFER_F1_EOP_CLR = 0;
  localparam int UFER_C0_TX_EN = 5;
  localparam int UFER_C0_RX_EN = 4;
  localparam int UFER_C1_TX_EN = 5;
  localparam int UFER_C2_BUS_RESET_CLR = 6;

  // ****************************************
  // reset values and responses
  // ****************************************
  localparam logic [7:0] UFER_BYTE_RESET = 8'h00;
  localparam logic [1:0] UFER_RESP_OKAY = 2'h0;
  localparam logic [1:0] UFER_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    UFER_HS_NONE = 2'b00,
    UFER_HS_ACK = 2'b01,
    UFER_HS_NAK = 2'b10
  } ufer_hs_t;

  // link events from the serial engine, one-cycle pulses
  typedef struct packed {
    logic tok_valid;
    logic [6:0] tok_addr;
    logic [3:0] tok_ep;
    logic tok_in;
    logic tx0_acked;
    logic rx0_acked;
    logic tx12_acked;
    logic eop_seen;
    logic bus_reset_seen;
    logic bus_activity;
    logic rx_wr;
    logic [2:0] rx_idx;
    logic [7:0] rx_byte;
  } ufer_link_t;

endpackage : ufer_pkg

// ===== rtl/ufer_regs.sv
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Behaviour
// - disabled module ignores every token
// - seven-bit function address, read/write, reset clear
// - ep0 tx done set on acked send
// - ep0 tx done set forces NAK on IN
// - write one clears ep0 tx done
// - ep0 rx done set on acked receive
// - ep0 rx done set forces NAK on OUT
// - write one clears ep0 rx done
// - bus reset sets flag, internal reset out
// - suspend stops module clock
// - ep0 flags raise interrupt when enabled
// - shared tx done set on acked send
// - shared tx done forces NAK on IN
// - write one clears shared tx done
// - end-of-packet flag set on detected EOP
// - write one clears end-of-packet flag
// - activity during suspend sets resume flag
// - write one clears resume flag
// - eop and shared tx interrupt enables
// - twenty-four data buffer registers
// - ep0 IN NAK when tx disabled
module ufer_regs import ufer_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // serial engine side
  input wire ufer_link_t link,
  input wire logic [2:0] tx_rd_idx,
  output logic [7:0] ep0_tx_byte,
  output logic [7:0] ep12_tx_byte,
  output logic [1:0] handshake,
  output logic token_hit,
  // system
  output logic usb_irq,
  output logic internal_reset,
  output logic module_clk_stop
);

  // ****************************************
  // storage
  // ****************************************
  logic module_enable;
  logic [6:0] function_addr_field;
  logic ctrl_ep_tx_done, ctrl_ep_rx_done, bus_reset_flag, suspend_bit;
  logic ctrl_ep_tx_irq_en, ctrl_ep_rx_irq_en;
  logic shared_ep_tx_done, end_of_packet_flag, resume_flag;
  logic shared_ep_tx_irq_en, end_of_packet_irq_en;
  logic [7:0] ctrl_zero, ctrl_one, ctrl_two;
  logic [7:0] ep0_rx_mem [8];
  logic [7:0] ep0_tx_mem [8];
  logic [7:0] ep12_tx_mem [8];

  // ****************************************
  // bus slave
  // ****************************************
  logic aw_held, w_held;
  logic [31:0] aw_addr, w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic [7:0] wr_idx, wd;

  function automatic logic [7:0] word_index(input logic [31:0] a);
    return a[9:2];
  endfunction : word_index

  function automatic logic mapped(input logic [7:0] i);
    return (i >= UFER_EP0_DATA_FIRST && i <= UFER_EP12_DATA_LAST) ||
           (i >= UFER_ENDPOINT_CONTROL_TWO && i <= UFER_RECEIVE_STATUS);
  endfunction : mapped

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_idx = word_index(aw_addr);
  // byte lane 0 carries the register; other lanes are ignored
  assign wd = w_strb[0] ? w_data[7:0] : 8'h00;
  logic wr_ok;
  assign wr_ok = wr_fire && w_strb[0] && aw_addr[31:10] == 22'h000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 32'h00000000;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= UFER_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped(wr_idx) && aw_addr[31:10] == 22'h000000 ?
                     UFER_RESP_OKAY : UFER_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  function automatic logic [7:0] read_byte(input logic [7:0] i);
    logic [7:0] v;
    v = 8'h00;
    if (i >= UFER_EP0_DATA_FIRST && i <= UFER_EP0_DATA_LAST) begin
      v = ep0_rx_mem[i[2:0]];
    end else if (i == UFER_ENDPOINT_CONTROL_TWO) begin
      v = ctrl_two & 8'h3F;
    end else if (i == UFER_FUNCTION_ADDRESS) begin
      v = {module_enable, function_addr_field};
    end else if (i == UFER_EVENT_FLAGS_ZERO) begin
      v = {ctrl_ep_tx_done, ctrl_ep_rx_done, bus_reset_flag, suspend_bit,
           ctrl_ep_tx_irq_en, ctrl_ep_rx_irq_en, 2'b00};
    end else if (i == UFER_EVENT_FLAGS_ONE) begin
      v = {shared_ep_tx_done, end_of_packet_flag, resume_flag, 1'b0,
           shared_ep_tx_irq_en, end_of_packet_irq_en, 2'b00};
    end else if (i == UFER_ENDPOINT_CONTROL_ZERO) begin
      v = ctrl_zero;
    end else if (i == UFER_ENDPOINT_CONTROL_ONE) begin
      v = ctrl_one;
    end
    return v;
  endfunction : read_byte

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= UFER_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, read_byte(word_index(s_axi_araddr))};
        s_axi_rresp <= mapped(word_index(s_axi_araddr)) &&
                       s_axi_araddr[31:10] == 22'h000000 ?
                       UFER_RESP_OKAY : UFER_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      module_enable <= 1'b0;
      function_addr_field <= 7'h00;
    end else if (wr_ok && wr_idx == UFER_FUNCTION_ADDRESS) begin
      module_enable <= wd[UFER_ENABLE_BIT];
      function_addr_field <= wd[6:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_zero <= UFER_BYTE_RESET;
      ctrl_one <= UFER_BYTE_RESET;
      ctrl_two <= UFER_BYTE_RESET;
    end else if (wr_ok) begin
      if (wr_idx == UFER_ENDPOINT_CONTROL_ZERO) begin
        ctrl_zero <= wd;
      end else if (wr_idx == UFER_ENDPOINT_CONTROL_ONE) begin
        ctrl_one <= wd;
      end else if (wr_idx == UFER_ENDPOINT_CONTROL_TWO) begin
        ctrl_two <= wd & 8'h3F;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ep_tx_irq_en <= 1'b0;
      ctrl_ep_rx_irq_en <= 1'b0;
      shared_ep_tx_irq_en <= 1'b0;
      end_of_packet_irq_en <= 1'b0;
      suspend_bit <= 1'b0;
    end else if (wr_ok && wr_idx == UFER_EVENT_FLAGS_ZERO) begin
      ctrl_ep_tx_irq_en <= wd[UFER_F0_TX_IE];
      ctrl_ep_rx_irq_en <= wd[UFER_F0_RX_IE];
      suspend_bit <= wd[UFER_F0_SUSPEND];
    end else if (wr_ok && wr_idx == UFER_EVENT_FLAGS_ONE) begin
      shared_ep_tx_irq_en <= wd[UFER_F1_TX_IE];
      end_of_packet_irq_en <= wd[UFER_F1_EOP_IE];
    end
  end

  // ****************************************
  // event flags: set wins over clear
  // ****************************************
  logic clr0, clr1, clr2;
  assign clr0 = wr_ok && wr_idx == UFER_EVENT_FLAGS_ZERO;
  assign clr1 = wr_ok && wr_idx == UFER_EVENT_FLAGS_ONE;
  assign clr2 = wr_ok && wr_idx == UFER_ENDPOINT_CONTROL_TWO;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ep_tx_done <= 1'b0;
      ctrl_ep_rx_done <= 1'b0;
      shared_ep_tx_done <= 1'b0;
      end_of_packet_flag <= 1'b0;
      resume_flag <= 1'b0;
    end else begin
      if (link.tx0_acked) begin
        ctrl_ep_tx_done <= 1'b1;
      end else if (clr0 && wd[UFER_F0_TX_CLR]) begin
        ctrl_ep_tx_done <= 1'b0;
      end
      if (link.rx0_acked) begin
        ctrl_ep_rx_done <= 1'b1;
      end else if (clr0 && wd[UFER_F0_RX_CLR]) begin
        ctrl_ep_rx_done <= 1'b0;
      end
      if (link.tx12_acked) begin
        shared_ep_tx_done <= 1'b1;
      end else if (clr1 && wd[UFER_F1_TX_CLR]) begin
        shared_ep_tx_done <= 1'b0;
      end
      if (link.eop_seen) begin
        end_of_packet_flag <= 1'b1;
      end else if (clr1 && wd[UFER_F1_EOP_CLR]) begin
        end_of_packet_flag <= 1'b0;
      end
      if (link.bus_activity && suspend_bit) begin
        resume_flag <= 1'b1;
      end else if (clr1 && wd[UFER_F1_RESUME_CLR]) begin
        resume_flag <= 1'b0;
      end
    end
  end

  // the bus reset flag survives the internal reset it causes; only power-on reset (aresetn)
  // or a one written to bit 6 of endpoint control two clears it, so software can tell why it restarted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_reset_flag <= 1'b0;
      internal_reset <= 1'b0;
    end else begin
      internal_reset <= link.bus_reset_seen;
      if (link.bus_reset_seen) begin
        bus_reset_flag <= 1'b1;
      end else if (clr2 && wd[UFER_C2_BUS_RESET_CLR]) begin
        bus_reset_flag <= 1'b0;
      end
    end
  end

  // ****************************************
  // data buffers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (wr_ok && wr_idx >= UFER_EP0_DATA_FIRST && wr_idx <= UFER_EP0_DATA_LAST) begin
      ep0_tx_mem[wr_idx[2:0]] <= wd;
    end
    if (wr_ok && wr_idx >= UFER_EP12_DATA_FIRST && wr_idx <= UFER_EP12_DATA_LAST) begin
      ep12_tx_mem[wr_idx[2:0]] <= wd;
    end
    if (link.rx_wr) begin
      ep0_rx_mem[link.rx_idx] <= link.rx_byte;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ep0_tx_byte <= 8'h00;
      ep12_tx_byte <= 8'h00;
    end else begin
      ep0_tx_byte <= ep0_tx_mem[tx_rd_idx];
      ep12_tx_byte <= ep12_tx_mem[tx_rd_idx];
    end
  end

  // ****************************************
  // token answer
  // ****************************************
  logic hit;
  assign hit = link.tok_valid && module_enable && !suspend_bit &&
               link.tok_addr == function_addr_field;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      handshake <= UFER_HS_NONE;
      token_hit <= 1'b0;
    end else begin
      token_hit <= hit;
      if (!hit) begin
        handshake <= UFER_HS_NONE;
      end else if (link.tok_ep == 4'h0 && link.tok_in) begin
        handshake <= (!ctrl_zero[UFER_C0_TX_EN] || ctrl_ep_tx_done) ?
                     UFER_HS_NAK : UFER_HS_ACK;
      end else if (link.tok_ep == 4'h0) begin
        handshake <= (!ctrl_zero[UFER_C0_RX_EN] || ctrl_ep_rx_done) ?
                     UFER_HS_NAK : UFER_HS_ACK;
      end else begin
        handshake <= (!ctrl_one[UFER_C1_TX_EN] || shared_ep_tx_done) ?
                     UFER_HS_NAK : UFER_HS_ACK;
      end
    end
  end

  // ****************************************
  // interrupt and clock gate
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      usb_irq <= 1'b0;
      module_clk_stop <= 1'b0;
    end else begin
      usb_irq <= (ctrl_ep_tx_done && ctrl_ep_tx_irq_en) ||
                 (ctrl_ep_rx_done && ctrl_ep_rx_irq_en) ||
                 (shared_ep_tx_done && shared_ep_tx_irq_en) ||
                 (end_of_packet_flag && end_of_packet_irq_en);
      module_clk_stop <= suspend_bit;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  tx_done_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    link.tx0_acked |=> ctrl_ep_tx_done) else $error("tx done not set");
  tx_done_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clr0 && wd[UFER_F0_TX_CLR] && !link.tx0_acked |=> !ctrl_ep_tx_done)
    else $error("tx done not cleared");
  rx_done_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clr0 && wd[UFER_F0_RX_CLR] && !link.rx0_acked |=> !ctrl_ep_rx_done)
    else $error("rx done not cleared");
  in_nak_a: assert property (@(posedge aclk) disable iff (!aresetn)
    hit && link.tok_ep == 4'h0 && link.tok_in && ctrl_ep_tx_done
    |=> handshake == UFER_HS_NAK) else $error("ep0 IN not nakked");
  disabled_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !module_enable |=> handshake == UFER_HS_NONE) else $error("answer while off");
  resume_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    link.bus_activity && suspend_bit |=> resume_flag) else $error("resume missed");
  eop_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    link.eop_seen |=> end_of_packet_flag) else $error("eop missed");
  irq_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    end_of_packet_flag && end_of_packet_irq_en |=> usb_irq)
    else $error("irq missing");
  shared_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clr1 && wd[UFER_F1_TX_CLR] && !link.tx12_acked |=> !shared_ep_tx_done)
    else $error("shared done not cleared");

endmodule : ufer_regs

// ===== verif/ufer_host.sv
`timescale 1ns/1ps
// ********
// host controller stand-in
// ********
module ufer_host import ufer_pkg::*; (
  // clock
  input wire logic aclk,
  // device answer
  input wire logic [1:0] handshake,
  input wire logic token_hit,
  // link events to the device
  output ufer_link_t link
);
  initial link = '0;
  // one-cycle pulse; released fields go inverse so stale data never reads as live
  task automatic send(input ufer_link_t l);
    ufer_link_t m;
    m = '0;
    m.tok_addr = ~l.tok_addr;
    m.tok_ep = ~l.tok_ep;
    m.rx_idx = ~l.rx_idx;
    m.rx_byte = ~l.rx_byte;
    @(posedge aclk);
    link <= l;
    @(posedge aclk);
    link <= m;
  endtask : send
  task automatic token(input logic [6:0] a, input logic [3:0] e, input logic in_dir,
                       output logic [1:0] hs, output logic hit);
    ufer_link_t l;
    l = '0;
    l.tok_valid = 1'h1;
    l.tok_addr = a;
    l.tok_ep = e;
    l.tok_in = in_dir;
    send(l);
    #1;
    hs = handshake;
    hit = token_hit;
    @(posedge aclk);
    #1;
    hs = hs | handshake;
    hit = hit | token_hit;
  endtask : token
  task automatic ev(input int k);
    ufer_link_t l;
    l = '0;
    case (k)
      0: l.tx0_acked = 1'h1;
      1: l.rx0_acked = 1'h1;
      2: l.tx12_acked = 1'h1;
      3: l.eop_seen = 1'h1;
      4: l.bus_reset_seen = 1'h1;
      default: l.bus_activity = 1'h1;
    endcase
    send(l);
  endtask : ev
  task automatic rx(input logic [2:0] i, input logic [7:0] b);
    ufer_link_t l;
    l = '0;
    l.rx_wr = 1'h1;
    l.rx_idx = i;
    l.rx_byte = b;
    send(l);
  endtask : rx
endmodule : ufer_host

// ===== verif/usb_function_endpoint_regs_test.sv
`timescale 1ns/1ps
module usb_function_endpoint_regs_test import ufer_pkg::*;;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, token_hit, hit, usb_irq, internal_reset;
  logic module_clk_stop;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, handshake, hs;
  logic [2:0] tx_rd_idx;
  logic [7:0] ep0_tx_byte, ep12_tx_byte;
  ufer_link_t link;
  int n_errors = 0;
  int cmp_count = 0;
  int seed = 55;
  int rst_seen = 0;
  int a, addr_r, f0, f1, c0, c1;
  int tx0[8], rx0[8], tx12[8];
  ufer_regs i_ufer_regs (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link),
    .tx_rd_idx(tx_rd_idx), .ep0_tx_byte(ep0_tx_byte), .ep12_tx_byte(ep12_tx_byte),
    .handshake(handshake), .token_hit(token_hit), .usb_irq(usb_irq),
    .internal_reset(internal_reset), .module_clk_stop(module_clk_stop));
  ufer_host i_ufer_host (.aclk(aclk), .handshake(handshake), .token_hit(token_hit),
    .link(link));
  initial begin
    aclk = 1'h0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) if (internal_reset === 1'h1) rst_seen <= rst_seen + 1;
  // ********
  // model and checks
  // ********
  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_v
  task automatic chk_b(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t bit %b expected %b", $time, got, exp);
    end
  endtask : chk_b
  function automatic logic mapped(input int i);
    return (i >= 'h20 && i <= 'h2F) || (i >= 'h37 && i <= 'h3D);
  endfunction : mapped
  function automatic logic exp_irq();
    return (f0 & 'h88) == 'h88 || (f0 & 'h44) == 'h44 || (f1 & 'h88) == 'h88
      || (f1 & 'h44) == 'h44;
  endfunction : exp_irq
  function automatic int mdl_rd(input int i);
    if (i >= 'h20 && i <= 'h27) return rx0[i - 'h20];
    if (i == 'h38) return addr_r;
    if (i == 'h39) return f0;
    if (i == 'h3A) return f1;
    if (i == 'h3B) return c0;
    if (i == 'h3C) return c1;
    return 0;
  endfunction : mdl_rd
  // clear bits act only on a one; flag bits themselves ignore writes
  task automatic mdl_wr(input int i, input int d);
    if (i == 'h38) addr_r = d;
    if (i == 'h3B) c0 = d;
    if (i == 'h3C) c1 = d;
    if (i >= 'h20 && i <= 'h27) tx0[i - 'h20] = d;
    if (i >= 'h28 && i <= 'h2F) tx12[i - 'h28] = d;
    if (i == 'h37 && (d & 'h40) != 0) f0 &= 'hDF;
    if (i == 'h39) f0 = (f0 & 'hE0 & ~((d & 2) << 6) & ~((d & 1) << 6)) | (d & 'h1C);
    if (i == 'h3A) f1 = (f1 & 'hE0 & ~((d & 2) << 6) & ~((d & 1) << 6)
      & ~((d & 'h10) << 1)) | (d & 'h0C);
  endtask : mdl_wr
  task automatic st();
    repeat (3) @(posedge aclk);
    #1;
    chk_b(usb_irq, exp_irq());
  endtask : st
  task automatic wr(input int i, input int d);
    @(posedge aclk);
    awaddr <= 32'(i * 4);
    wdata <= 32'(d);
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
    chk_v(32'(bresp), 32'(mapped(i) ? UFER_RESP_OKAY : UFER_RESP_SLVERR));
    if (mapped(i)) mdl_wr(i, d);
    st();
  endtask : wr
  task automatic rd(input int i);
    @(posedge aclk);
    araddr <= 32'(i * 4);
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h0;
    chk_v(32'(rresp), 32'(mapped(i) ? UFER_RESP_OKAY : UFER_RESP_SLVERR));
    if (mapped(i)) chk_v(rdata, 32'(mdl_rd(i)));
  endtask : rd
  task automatic ev(input int k);
    i_ufer_host.ev(k);
    if (k == 0) f0 |= 'h80;
    if (k == 1) f0 |= 'h40;
    if (k == 2) f1 |= 'h80;
    if (k == 3) f1 |= 'h40;
    if (k == 4) f0 |= 'h20;
    if (k == 5 && (f0 & 'h10) != 0) f1 |= 'h20;
    st();
  endtask : ev
  // x: 0 silent, 2 refused, 3 served
  task automatic tok(input int ta, input int e, input int in_dir, input int x);
    i_ufer_host.token(7'(ta), 4'(e), 1'(in_dir), hs, hit);
    if (x == 3) chk_v(32'(hs), 32'(UFER_HS_ACK));
    else chk_v(32'(hs), 32'(x));
    chk_b(hit, 1'(x != 0));
  endtask : tok
  task automatic wrap_up();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (5000) @(posedge aclk);
    n_errors++;
    wrap_up();
  end
  // ********
  // scenarios
  // ********
  initial begin
    {awaddr, wdata, araddr} = '0;
    {awvalid, wvalid, bready, arvalid, rready, aresetn} = '0;
    wstrb = 4'h0;
    tx_rd_idx = 3'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    for (int i = 'h38; i <= 'h3D; i++) rd(i);
    chk_b(module_clk_stop, 1'h0);
    a = $random(seed) & 'h7F;
    wr('h38, a);
    tok(a, 0, 1, 0);
    wr('h38, 'h80 | a);
    rd('h38);
    tok(a ^ 1, 0, 1, 0);
    tok(a, 0, 1, 2);
    wr('h3B, 'h30);
    wr('h3C, 'h20);
    wr('h39, 'h0C);
    wr('h3A, 'h0C);
    for (int i = 'h39; i <= 'h3C; i++) rd(i);
    tok(a, 0, 1, 3);
    for (int i = 0; i < 8; i++) begin
      wr('h20 + i, $random(seed) & 'hFF);
      wr('h28 + i, $random(seed) & 'hFF);
      rx0[i] = $random(seed) & 'hFF;
      i_ufer_host.rx(3'(i), 8'(rx0[i]));
      @(posedge aclk);
      tx_rd_idx <= 3'(i);
      repeat (2) @(posedge aclk);
      #1;
      chk_v(32'(ep0_tx_byte), 32'(tx0[i]));
      chk_v(32'(ep12_tx_byte), 32'(tx12[i]));
      rd('h20 + i);
    end
    ev(0);
    rd('h39);
    tok(a, 0, 1, 2);
    wr('h39, 'h8C);
    rd('h39);
    wr('h39, 'h0E);
    rd('h39);
    ev(1);
    tok(a, 0, 0, 2);
    wr('h39, 'h4D);
    rd('h39);
    ev(2);
    tok(a, 1, 1, 2);
    wr('h3A, 'h0E);
    ev(3);
    wr('h3A, 'h4C);
    rd('h3A);
    wr('h3A, 'h0D);
    rd('h3A);
    ev(5);
    wr('h39, 'h1C);
    chk_b(module_clk_stop, 1'h1);
    tok(a, 0, 1, 0);
    ev(5);
    rd('h3A);
    wr('h3A, 'h1C);
    wr('h39, 'h0C);
    chk_b(module_clk_stop, 1'h0);
    rd('h3A);
    ev(0);
    wr('h39, 'h00);
    wr('h39, 'h02);
    wr('h3A, 'h00);
    chk_v(32'(rst_seen), 32'h0);
    ev(4);
    chk_v(32'(rst_seen), 32'h1);
    rd('h39);
    wr('h37, 'h40);
    rd('h39);
    rd('h30);
    wr('h00, 'h55);
    rd('h28);
    wr('h138, 'h00);
    rd('h38);
    rd('h120);
    wrap_up();
  end
endmodule : usb_function_endpoint_regs_test
